// >>> verilog/atc_cfg.svh
/*
 Register offsets, field positions, reset values and counts of the timer block.
 Assumes inclusion by bare name from the design module, the property module and the bench.
*/
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH
// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define ATC_OFS_CTRL_A     6'h00
`define ATC_OFS_CTRL_B     6'h04
`define ATC_OFS_COUNT      6'h08
`define ATC_OFS_CMP_A      6'h0C
`define ATC_OFS_CMP_B      6'h10
`define ATC_OFS_ASYNC      6'h14
`define ATC_OFS_IRQ_STAT   6'h18
`define ATC_OFS_IRQ_EN     6'h1C
`define ATC_OFS_IRQ_CLR    6'h20
// -----------------------------------------------------------------
// Control B fields
// -----------------------------------------------------------------
`define ATC_B_FOC_A        7
`define ATC_B_FOC_B        6
`define ATC_B_WGM2         3
`define ATC_B_CS_HI        2
`define ATC_B_CS_LO        0
// -----------------------------------------------------------------
// Control A fields
// -----------------------------------------------------------------
`define ATC_A_COMA_HI      7
`define ATC_A_COMA_LO      6
`define ATC_A_COMB_HI      5
`define ATC_A_COMB_LO      4
`define ATC_A_WGM_HI       1
`define ATC_A_WGM_LO       0
// -----------------------------------------------------------------
// Values
// -----------------------------------------------------------------
`define ATC_BOTTOM         8'h00
`define ATC_MAX            8'hFF
`define ATC_RST_CTRL       8'h00
`define ATC_RST_CMP        8'h00
`define ATC_IRQ_OVF        0
`define ATC_IRQ_CMPA       1
`define ATC_IRQ_CMPB       2
`endif

// >>> verilog/atc_pkg.sv
/*
 Types shared by the timer block: waveform modes and bus request carrier.
 Assumes Avalon-MM slave access with 32-bit data.
*/
package atc_pkg;
   typedef enum logic [2:0] {
      ATC_WG_NORMAL   = 3'b000,
      ATC_WG_PWM_PC   = 3'b001,
      ATC_WG_CTC      = 3'b010,
      ATC_WG_FAST     = 3'b011,
      ATC_WG_RSV4     = 3'b100,
      ATC_WG_PWM_PC_A = 3'b101,
      ATC_WG_RSV6     = 3'b110,
      ATC_WG_FAST_A   = 3'b111
   } atc_wgm_t;

   typedef struct packed {
      logic [5:0]  address;
      logic        read;
      logic        write;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } atc_bus_req_t;
endpackage : atc_pkg

// >>> verilog/atc_timer.sv
/*
 Eight-bit up/down timer/counter with two compare channels and an Avalon-MM slave.
 Assumes one clock clk_sys; oscillator pin synchronised through two flops, a third flop finds its rising edge.
*/
// Notes on behaviour
// RQ1: Bottom is recognised whenever the count equals zero.
// RQ2: Max is recognised whenever the count equals all ones.
// RQ3: Top is max or compare A value, per waveform mode.
// RQ4: Counter is eight bits and counts up or down.
// RQ5: Timer clock is the system clock unless async select picks oscillator pin.
// RQ6: Clock select field bits two to zero picks the tick source.
// RQ7: Force A acts only in non-PWM modes.
// RQ8: Force A strobes a compare match; output A follows its output mode.
// RQ9: Forced A compare raises no flag and never clears the counter.
// RQ10: Force A reads back as zero.
// RQ11: Force B acts only in non-PWM modes.
// RQ12: Force B strobes a compare match; output B follows its output mode.
// RQ13: Forced B compare raises no flag and never clears the counter.
// RQ14: Force B reads back as zero.
// RQ15: Software writes force bits as zero while a PWM mode runs.
// RQ16: Control B bits five and four read as zero.
// RQ17: Counter holds when no clock source is selected.
// RQ18: A real compare match sets that channel's flag, which may interrupt.
// RQ19: Normal mode counts up by one and wraps from max to zero.
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"
module atc_timer #(
   parameter int W = 8
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rstn,
   input  wire atc_pkg::atc_bus_req_t  avs_req,
   output var  logic [31:0]            avs_readdata,
   output var  logic                   avs_waitrequest,
   input  wire logic                   osc_pin_in,
   output var  logic                   osc_pin_out,
   output var  logic                   compare_a_output,
   output var  logic                   compare_b_output,
   output var  logic                   irq
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0]   ctrl_a_r;
   logic [3:0]   ctrl_b_r;
   logic [W-1:0] count_r;
   logic [W-1:0] cmp_a_r;
   logic [W-1:0] cmp_b_r;
   logic         async_sel_r;
   logic [2:0]   stat_r;
   logic [2:0]   en_r;
   logic         dir_down_r;
   logic         oca_r;
   logic         ocb_r;
   logic [9:0]   presc_r;
   logic         osc_s1_r;
   logic         osc_s2_r;
   logic         osc_s3_r;
   logic         ack_r;
   logic [31:0]  rdata_r;
   logic         irq_r;
   logic         osc_out_r;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   wire logic        acc    = (avs_req.read | avs_req.write) & ~ack_r;
   wire logic        wr     = avs_req.write & acc & avs_req.byteenable[0];
   wire logic [5:0]  adr    = avs_req.address;
   wire logic [7:0]  wd     = avs_req.writedata[7:0];
   wire logic        wr_a   = wr & (adr == `ATC_OFS_CTRL_A);
   wire logic        wr_b   = wr & (adr == `ATC_OFS_CTRL_B);
   wire logic        wr_cnt = wr & (adr == `ATC_OFS_COUNT);
   wire logic        wr_ca  = wr & (adr == `ATC_OFS_CMP_A);
   wire logic        wr_cb  = wr & (adr == `ATC_OFS_CMP_B);
   wire logic        wr_as  = wr & (adr == `ATC_OFS_ASYNC);
   wire logic        wr_en  = wr & (adr == `ATC_OFS_IRQ_EN);
   wire logic        wr_clr = wr & (adr == `ATC_OFS_IRQ_CLR);

   wire atc_pkg::atc_wgm_t wgm =
      atc_pkg::atc_wgm_t'({ctrl_b_r[`ATC_B_WGM2], ctrl_a_r[`ATC_A_WGM_HI:`ATC_A_WGM_LO]});
   wire logic non_pwm = (wgm == atc_pkg::ATC_WG_NORMAL) || (wgm == atc_pkg::ATC_WG_CTC);
   wire logic phase_c = (wgm == atc_pkg::ATC_WG_PWM_PC) || (wgm == atc_pkg::ATC_WG_PWM_PC_A);
   wire logic top_a   = (wgm == atc_pkg::ATC_WG_CTC) || (wgm == atc_pkg::ATC_WG_PWM_PC_A)
                        || (wgm == atc_pkg::ATC_WG_FAST_A);
   wire logic [W-1:0] top     = top_a ? cmp_a_r : W'(`ATC_MAX);                      // RQ3
   wire logic         at_bot  = (count_r == W'(`ATC_BOTTOM));                       // RQ1
   wire logic         at_max  = (count_r == W'(`ATC_MAX));                          // RQ2
   wire logic         at_top  = (count_r == top);
   wire logic         match_a = (count_r == cmp_a_r);
   wire logic         match_b = (count_r == cmp_b_r);

   // Force strobes only act in non-PWM modes and never touch flags or count
   wire logic force_a = wr_b & wd[`ATC_B_FOC_A] & non_pwm;                          // RQ7
   wire logic force_b = wr_b & wd[`ATC_B_FOC_B] & non_pwm;                          // RQ11

   // -----------------------------------------------------------------
   // Tick selection
   // -----------------------------------------------------------------
   // Oscillator pin is slow; sampled edges make the tick, no second domain
   wire logic osc_edge = osc_s2_r & ~osc_s3_r;
   wire logic [2:0] cs = ctrl_b_r[`ATC_B_CS_HI:`ATC_B_CS_LO];
   wire logic [9:0] presc_nxt = presc_r + 10'h001;
   wire logic base = async_sel_r ? osc_edge : 1'b1;                                 // RQ5
   logic      tick;
   always_comb begin
      case (cs)                                                                     // RQ6
         3'h0:    tick = 1'b0;                                                      // RQ17
         3'h1:    tick = base;
         3'h2:    tick = base & (presc_r[2:0] == 3'h7);
         3'h3:    tick = base & (presc_r[4:0] == 5'h1F);
         3'h4:    tick = base & (presc_r[5:0] == 6'h3F);
         3'h5:    tick = base & (presc_r[6:0] == 7'h7F);
         3'h6:    tick = base & (presc_r[7:0] == 8'hFF);
         default: tick = base & (presc_r == 10'h3FF);
      endcase
   end

   // -----------------------------------------------------------------
   // Counter
   // -----------------------------------------------------------------
   logic [W-1:0] count_nxt;
   logic         dir_nxt;
   always_comb begin
      count_nxt = count_r;
      dir_nxt   = dir_down_r;
      if (wr_cnt) begin
         count_nxt = wd[W-1:0];
      end else if (tick) begin
         if (phase_c) begin                                                         // RQ4
            if (!dir_down_r && at_top) begin
               dir_nxt   = 1'b1;
               count_nxt = count_r - W'(1);
            end else if (dir_down_r && at_bot) begin
               dir_nxt   = 1'b0;
               count_nxt = count_r + W'(1);
            end else begin
               count_nxt = dir_down_r ? count_r - W'(1) : count_r + W'(1);
            end
         end else begin
            dir_nxt   = 1'b0;
            // Genuine top only; forced matches never clear the count
            count_nxt = at_top ? W'(`ATC_BOTTOM) : count_r + W'(1);                 // RQ19 RQ9 RQ13
         end
      end
   end

   // -----------------------------------------------------------------
   // Compare outputs
   // -----------------------------------------------------------------
   function automatic logic oc_next(input logic [1:0] mode, input logic cur);
      case (mode)
         2'h1:    oc_next = ~cur;
         2'h2:    oc_next = 1'b0;
         2'h3:    oc_next = 1'b1;
         default: oc_next = cur;
      endcase
   endfunction : oc_next

   wire logic [1:0] com_a = ctrl_a_r[`ATC_A_COMA_HI:`ATC_A_COMA_LO];
   wire logic [1:0] com_b = ctrl_a_r[`ATC_A_COMB_HI:`ATC_A_COMB_LO];
   wire logic ev_a = force_a | (tick & match_a & non_pwm);                          // RQ8
   wire logic ev_b = force_b | (tick & match_b & non_pwm);                          // RQ12
   wire logic oca_nxt = ev_a ? oc_next(com_a, oca_r) : oca_r;
   wire logic ocb_nxt = ev_b ? oc_next(com_b, ocb_r) : ocb_r;

   // -----------------------------------------------------------------
   // Flags: set wins over clear; forced matches excluded
   // -----------------------------------------------------------------
   wire logic [2:0] set_ev = {tick & match_b, tick & match_a, tick & at_max & ~phase_c}; // RQ18
   wire logic [2:0] clr    = wr_clr ? wd[2:0] : 3'h0;
   wire logic [2:0] stat_nxt = set_ev | (stat_r & ~clr);

   // -----------------------------------------------------------------
   // Read mux
   // -----------------------------------------------------------------
   wire logic [7:0] rd_b = {2'b00, 2'b00, ctrl_b_r};                                // RQ10 RQ14 RQ16
   logic [7:0] rd_byte;
   always_comb begin
      if (adr == `ATC_OFS_CTRL_A) begin
         rd_byte = ctrl_a_r;
      end else if (adr == `ATC_OFS_CTRL_B) begin
         rd_byte = rd_b;
      end else if (adr == `ATC_OFS_COUNT) begin
         rd_byte = 8'(count_r);
      end else if (adr == `ATC_OFS_CMP_A) begin
         rd_byte = 8'(cmp_a_r);
      end else if (adr == `ATC_OFS_CMP_B) begin
         rd_byte = 8'(cmp_b_r);
      end else if (adr == `ATC_OFS_ASYNC) begin
         rd_byte = {7'h00, async_sel_r};
      end else if (adr == `ATC_OFS_IRQ_STAT) begin
         rd_byte = {5'h00, stat_r};
      end else if (adr == `ATC_OFS_IRQ_EN) begin
         rd_byte = {5'h00, en_r};
      end else begin
         rd_byte = 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // Sequential
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end else begin
         osc_s1_r <= osc_pin_in;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_a_r    <= `ATC_RST_CTRL;
         ctrl_b_r    <= 4'h0;
         cmp_a_r     <= W'(`ATC_RST_CMP);
         cmp_b_r     <= W'(`ATC_RST_CMP);
         async_sel_r <= 1'b0;
         en_r        <= 3'h0;
      end else begin
         if (wr_a)  ctrl_a_r    <= wd;
         if (wr_b)  ctrl_b_r    <= wd[3:0];
         if (wr_ca) cmp_a_r     <= wd[W-1:0];
         if (wr_cb) cmp_b_r     <= wd[W-1:0];
         if (wr_as) async_sel_r <= wd[0];
         if (wr_en) en_r        <= wd[2:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         count_r    <= W'(`ATC_BOTTOM);
         dir_down_r <= 1'b0;
         presc_r    <= 10'h000;
         oca_r      <= 1'b0;
         ocb_r      <= 1'b0;
         stat_r     <= 3'h0;
         irq_r      <= 1'b0;
      end else begin
         count_r    <= count_nxt;
         dir_down_r <= dir_nxt;
         presc_r    <= base ? presc_nxt : presc_r;
         oca_r      <= oca_nxt;
         ocb_r      <= ocb_nxt;
         stat_r     <= stat_nxt;
         irq_r      <= |(stat_nxt & en_r);
      end
   end

   // One wait cycle: request taken when ack_r is low, answered the next edge
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ack_r     <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         osc_out_r <= 1'b0;
      end else begin
         ack_r     <= acc;
         rdata_r   <= acc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         osc_out_r <= ~osc_s2_r;
      end
   end

   assign avs_readdata     = rdata_r;
   assign avs_waitrequest  = ~ack_r;
   assign compare_a_output = oca_r;
   assign compare_b_output = ocb_r;
   assign irq              = irq_r;
   assign osc_pin_out      = osc_out_r;
endmodule : atc_timer
`default_nettype wire

// >>> sim/atc_timer_props.sv
/*
 Port assertions for the timer block.
 Assumes binding to atc_timer and the one-cycle bus answer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"
module atc_timer_props #(
   parameter int W = 8
) (
   input wire logic                  clk_sys,
   input wire logic                  rstn,
   input wire atc_pkg::atc_bus_req_t avs_req,
   input wire logic [31:0]           avs_readdata,
   input wire logic                  avs_waitrequest,
   input wire logic                  osc_pin_in,
   input wire logic                  osc_pin_out,
   input wire logic                  compare_a_output,
   input wire logic                  compare_b_output,
   input wire logic                  irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire rd_ack = !avs_waitrequest && avs_req.read;
   wire rd_b   = rd_ack && avs_req.address == `ATC_OFS_CTRL_B;
   sequence take_s;
      (avs_req.read || avs_req.write) && avs_waitrequest;
   endsequence
   // Only safe while the counter is already stopped, as the bench keeps it
   sequence force_s;
      take_s ##0 avs_req.write && avs_req.address == `ATC_OFS_CTRL_B && avs_req.byteenable[0]
         && avs_req.writedata[7:6] != 2'b00 && avs_req.writedata[2:0] == 3'h0 && !irq;
   endsequence
   a_take_answer:
      assert property (take_s |=> !avs_waitrequest) else $error("no answer after request");
   a_ack_single:
      assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
   a_idle_rdata:
      assert property (avs_waitrequest |-> avs_readdata == 32'h0) else $error("stray read data");
   a_force_a_zero:
      assert property (rd_b |-> !avs_readdata[7]) else $error("force a reads one");
   a_force_b_zero:
      assert property (rd_b |-> !avs_readdata[6]) else $error("force b reads one");
   a_reserved_zero:
      assert property (rd_b |-> avs_readdata[5:4] == 2'b00) else $error("reserved bits set");
   a_unmapped_zero:
      assert property (rd_ack && avs_req.address > `ATC_OFS_IRQ_CLR |-> avs_readdata == 32'h0)
         else $error("unmapped read not zero");
   a_force_no_irq:
      assert property (force_s |=> !irq [*4]) else $error("forced compare raised irq");
endmodule : atc_timer_props
bind atc_timer atc_timer_props #(.W(W)) i_atc_timer_props (.clk_sys(clk_sys), .rstn(rstn),
   .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out), .compare_a_output(compare_a_output),
   .compare_b_output(compare_b_output), .irq(irq));
`default_nettype wire

// >>> sim/atc_timer_bench.sv
/*
 Self-checking bench for the timer block.
 Assumes the register offsets of atc_cfg.svh and the one-cycle bus answer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"
module atc_timer_bench;
   logic                  clk_sys, rstn, osc_pin_in, waitreq, osc_out, out_a, out_b, irq;
   atc_pkg::atc_bus_req_t req;
   logic [31:0]           rdata;
   logic [7:0]            q;
   int                    bad_count, check_count, n;
   logic [1:0]            modes [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
   logic                  exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
   atc_timer i_atc_timer (.clk_sys(clk_sys), .rstn(rstn), .avs_req(req), .avs_readdata(rdata),
      .avs_waitrequest(waitreq), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_out),
      .compare_a_output(out_a), .compare_b_output(out_b), .irq(irq));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ------------------------------------------
   // Tasks
   // ------------------------------------------
   task automatic complete_run;
      if (bad_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask : chk
   // Extra edge at the end keeps two drives of one strobe out of one time step
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int k;
      req <= '{address: a, read: !w, write: w, byteenable: 4'hF, writedata: {24'h0, d}};
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (waitreq !== 1'b0 && k < 20);
      q = rdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (k >= 20) begin
         bad_count++;
         complete_run();
      end
      @(posedge clk_sys);
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, q, e);
   endtask : rd
   // ------------------------------------------
   // Sequence
   // ------------------------------------------
   initial begin
      rstn = 1'b0;
      osc_pin_in = 1'b0;
      req = '0;
      bad_count = 0;
      check_count = 0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rd("ctrl_b reset", `ATC_OFS_CTRL_B, 8'h00);
      wr(`ATC_OFS_CTRL_B, 8'hF8);
      rd("ctrl_b readback", `ATC_OFS_CTRL_B, 8'h08);
      rd("unmapped", 6'h3C, 8'h00);
      wr(`ATC_OFS_CTRL_B, 8'h00);
      wr(`ATC_OFS_COUNT, 8'h10);
      repeat (8) @(posedge clk_sys);
      rd("stopped count", `ATC_OFS_COUNT, 8'h10);
      wr(`ATC_OFS_CMP_A, 8'hF8);
      wr(`ATC_OFS_CMP_B, 8'h80);
      wr(`ATC_OFS_COUNT, 8'hF0);
      wr(`ATC_OFS_IRQ_EN, 8'h01);
      wr(`ATC_OFS_CTRL_B, 8'h01);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 100) begin
         bad_count++;
         complete_run();
      end
      wr(`ATC_OFS_CTRL_B, 8'h00);
      rd("flags", `ATC_OFS_IRQ_STAT, 8'h03);
      // Wrap to zero, then two more ticks until the stop write is taken
      rd("wrapped count", `ATC_OFS_COUNT, 8'h02);
      wr(`ATC_OFS_IRQ_EN, 8'h00);
      chk("irq masked", {7'h00, irq}, 8'h00);
      wr(`ATC_OFS_IRQ_EN, 8'h02);
      chk("irq enabled", {7'h00, irq}, 8'h01);
      wr(`ATC_OFS_IRQ_CLR, 8'h07);
      rd("cleared", `ATC_OFS_IRQ_STAT, 8'h00);
      chk("irq cleared", {7'h00, irq}, 8'h00);
      // Forced compares in clear-on-match mode, every output mode
      wr(`ATC_OFS_COUNT, 8'h33);
      foreach (modes[i]) begin
         wr(`ATC_OFS_CTRL_A, {modes[i], modes[i], 4'h2});
         wr(`ATC_OFS_CTRL_B, 8'hC0);
         chk("output a", {7'h00, out_a}, {7'h00, exps[i]});
         chk("output b", {7'h00, out_b}, {7'h00, exps[i]});
      end
      rd("count kept", `ATC_OFS_COUNT, 8'h33);
      rd("no flags", `ATC_OFS_IRQ_STAT, 8'h00);
      // Three ticks from F6 in clear-on-match mode: top is compare A
      wr(`ATC_OFS_COUNT, 8'hF6);
      wr(`ATC_OFS_CTRL_B, 8'h01);
      wr(`ATC_OFS_CTRL_B, 8'h00);
      rd("ctc wrap", `ATC_OFS_COUNT, 8'h00);
      rd("match flag", `ATC_OFS_IRQ_STAT, 8'h02);
      chk("match output a", {7'h00, out_a}, 8'h00);
      wr(`ATC_OFS_IRQ_CLR, 8'h07);
      wr(`ATC_OFS_CTRL_A, 8'h51);
      wr(`ATC_OFS_CTRL_B, 8'hC0);
      chk("pwm output a", {7'h00, out_a}, 8'h00);
      chk("pwm output b", {7'h00, out_b}, 8'h01);
      // Phase correct: three ticks from FE turn at max and come back down
      wr(`ATC_OFS_COUNT, 8'hFE);
      wr(`ATC_OFS_CTRL_B, 8'h01);
      wr(`ATC_OFS_CTRL_B, 8'h00);
      rd("up down count", `ATC_OFS_COUNT, 8'hFD);
      wr(`ATC_OFS_CTRL_A, 8'h00);
      wr(`ATC_OFS_COUNT, 8'h00);
      // Divide by eight: 64 edges with the field at 2 give eight ticks
      wr(`ATC_OFS_CTRL_B, 8'h02);
      repeat (61) @(posedge clk_sys);
      wr(`ATC_OFS_CTRL_B, 8'h00);
      rd("divided ticks", `ATC_OFS_COUNT, 8'h08);
      wr(`ATC_OFS_COUNT, 8'h00);
      wr(`ATC_OFS_ASYNC, 8'h01);
      wr(`ATC_OFS_CTRL_B, 8'h01);
      repeat (4) begin
         repeat (4) @(posedge clk_sys);
         osc_pin_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         chk("osc drive low", {7'h00, osc_out}, 8'h00);
         osc_pin_in <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      wr(`ATC_OFS_CTRL_B, 8'h00);
      rd("osc ticks", `ATC_OFS_COUNT, 8'h04);
      chk("osc drive idle", {7'h00, osc_out}, 8'h01);
      complete_run();
   end
endmodule : atc_timer_bench
`default_nettype wire
